// *** hdl/fbsm_top.sv ***
// Purpose: master/slave selection, slave configuration byte, bus failure watch
//          and program cycle gating of a small fieldbus station controller
// Assumes: all inputs synchronous to I_MCLK; reset stands for a power cycle
// Notes:   the byte is loaded at boot from I_NV_CFG if I_NV_VALID, else CFG_RST, and written back via O_NV_WR
module fbsm_top
  import fbsm_pkg::*;
#(
  parameter int P_FAIL_CYC = FAIL_CYC
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic        I_SEL_CLOSED,
  input  wire logic        I_NV_VALID,
  input  wire logic [7:0]  I_NV_CFG,
  input  wire logic        I_CYCLE_END,
  input  wire logic        I_XCHG_REQ,
  input  wire logic        I_XCHG_DONE,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic             O_IRQ,
  output logic             O_IS_MASTER,
  output logic             O_IS_PASSIVE,
  output logic [4:0]       O_STATION_ADDR,
  output logic             O_BUS_FAIL,
  output logic             O_PROG_EN,
  output logic             O_NV_WR,
  output logic [7:0]       O_NV_DATA
);

  localparam logic [TMR_W-1:0] FAIL_LIM = TMR_W'(P_FAIL_CYC - 1);

  fbsm_state_t      s_r;
  fbsm_state_t      s_nxt;
  logic             acc;
  logic             active;
  logic             halt_cond;
  logic             cfg_ok;
  fbsm_sel_t        sel;
  logic [STS_W-1:0] ev;
  logic [STS_W-1:0] rd_clr;

  function automatic fbsm_sel_t fbsm_dec(input logic [7:0] a);
    case (a)
      OFS_CFG:   fbsm_dec = FBSM_SEL_CFG;
      OFS_STS:   fbsm_dec = FBSM_SEL_STS;
      OFS_MASK:  fbsm_dec = FBSM_SEL_MASK;
      OFS_STATE: fbsm_dec = FBSM_SEL_STATE;
      default:   fbsm_dec = FBSM_SEL_NONE;
    endcase
  endfunction

  function automatic logic fbsm_addr_ok(input logic [4:0] a);
    fbsm_addr_ok = (a >= ADDR_MIN) && (a <= ADDR_MAX);
  endfunction

  // one wait state: the access phase is answered at the second edge
  assign acc    = I_PSEL & I_PENABLE & ~s_r.pready;
  assign sel    = fbsm_dec(I_PADDR);
  assign active = ~s_r.master & ~s_r.passive;
  assign halt_cond = active & s_r.fail & ~s_r.cfg[CFG_HALT_BIT];
  // the switch is read live so the byte cannot be changed once it is reopened
  assign cfg_ok = s_r.master & I_SEL_CLOSED & fbsm_addr_ok(I_PWDATA[4:0]);

  always_comb begin
    s_nxt = s_r;
    ev = '0;
    rd_clr = '0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.nv_wr = 1'b0;

    if (acc) begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = '0;
      case (sel)
        FBSM_SEL_CFG: begin
          s_nxt.prdata[7:0] = s_r.cfg;
          if (I_PWRITE) begin
            if (cfg_ok) begin
              s_nxt.cfg = I_PWDATA[7:0];
              s_nxt.nv_wr = 1'b1;
            end else begin
              ev[STS_REFUSED] = 1'b1;
            end
          end
        end
        FBSM_SEL_STS: begin
          if (!I_PWRITE) begin
            s_nxt.prdata[STS_W-1:0] = s_r.sts;
            rd_clr = '1;
          end
        end
        FBSM_SEL_MASK: begin
          s_nxt.prdata[STS_W-1:0] = s_r.mask;
          if (I_PWRITE) begin
            s_nxt.mask = I_PWDATA[STS_W-1:0];
          end
        end
        FBSM_SEL_STATE: begin
          s_nxt.prdata[SW_MASTER] = s_r.master;
          s_nxt.prdata[SW_PASSIVE] = s_r.passive;
          s_nxt.prdata[SW_FAIL] = s_r.fail;
          s_nxt.prdata[SW_ST_LSB +: 2] = s_r.st;
          s_nxt.prdata[SW_PROG] = s_r.prog_en;
          s_nxt.prdata[SW_ADR_LSB +: 5] = s_r.addr;
        end
        default: begin
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end

    // a master runs the bus itself, so only a slave watches for silence
    if (s_r.st != FBSM_BOOT && !s_r.master) begin
      if (I_XCHG_DONE) begin
        s_nxt.tmr = '0;
        if (s_r.fail) begin
          s_nxt.fail = 1'b0;
          ev[STS_OK] = 1'b1;
        end
      end else if (s_r.tmr >= FAIL_LIM) begin
        if (!s_r.fail) begin
          s_nxt.fail = 1'b1;
          ev[STS_FAIL] = 1'b1;
        end
      end else begin
        s_nxt.tmr = s_r.tmr + 1'b1;
      end
    end

    case (s_r.st)
      FBSM_BOOT: begin
        // mode is caught once here and frozen until the next power cycle
        s_nxt.master = I_SEL_CLOSED | ~I_NV_VALID;
        s_nxt.cfg = I_NV_VALID ? I_NV_CFG : CFG_RST;
        s_nxt.passive = ~s_nxt.master & s_nxt.cfg[CFG_KIND_BIT];
        if (s_nxt.master) begin
          s_nxt.addr = MASTER_ADDR;
        end else if (fbsm_addr_ok(s_nxt.cfg[CFG_ADDR_W-1:0])) begin
          s_nxt.addr = s_nxt.cfg[CFG_ADDR_W-1:0];
        end else begin
          s_nxt.addr = ADDR_MIN;
        end
        s_nxt.tmr = '0;
        s_nxt.st = FBSM_RUN;
      end
      FBSM_RUN: begin
        if (halt_cond) begin
          s_nxt.st = FBSM_HALT;
        end else if (active && I_CYCLE_END) begin
          if (!s_r.cfg[CFG_RATE_BIT] || I_XCHG_REQ) begin
            s_nxt.st = FBSM_XWAIT;
          end
        end
      end
      FBSM_XWAIT: begin
        if (halt_cond) begin
          s_nxt.st = FBSM_HALT;
        end else if (I_XCHG_DONE) begin
          s_nxt.st = FBSM_RUN;
        end
      end
      FBSM_HALT: begin
        // passive flag is untouched here, the slave stays active
        if (!s_r.fail || s_r.cfg[CFG_HALT_BIT]) begin
          s_nxt.st = FBSM_RUN;
        end
      end
      default: begin
        s_nxt.st = FBSM_BOOT;
      end
    endcase

    s_nxt.prog_en = (s_nxt.st == FBSM_RUN) & ~s_nxt.passive;
    // set wins over a clearing read in the same cycle
    s_nxt.sts = (s_r.sts & ~rd_clr) | ev;
    s_nxt.irq = |(s_nxt.sts & s_nxt.mask);
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign O_PRDATA       = s_r.prdata;
  assign O_PREADY       = s_r.pready;
  assign O_PSLVERR      = s_r.pslverr;
  assign O_IRQ          = s_r.irq;
  assign O_IS_MASTER    = s_r.master;
  assign O_IS_PASSIVE   = s_r.passive;
  assign O_STATION_ADDR = s_r.addr;
  assign O_BUS_FAIL     = s_r.fail;
  assign O_PROG_EN      = s_r.prog_en;
  assign O_NV_WR        = s_r.nv_wr;
  assign O_NV_DATA      = s_r.cfg;

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);

  sequence s_boot;
    s_r.st == FBSM_BOOT;
  endsequence

  sequence s_cfg_wr_bad;
    acc && I_PWRITE && sel == FBSM_SEL_CFG && !(s_r.master && I_SEL_CLOSED);
  endsequence

  sequence s_sync_end;
    s_r.st == FBSM_RUN && active && !s_r.cfg[CFG_RATE_BIT] && I_CYCLE_END && !s_r.fail;
  endsequence

  sequence s_async_idle;
    s_r.st == FBSM_RUN && active && s_r.cfg[CFG_RATE_BIT] && !I_CYCLE_END && !s_r.fail;
  endsequence

  a_apb_one_wait: assert property (acc |=> O_PREADY ##1 !O_PREADY)
    else $error("apb answer not one wait state");
  a_apb_unmapped: assert property (acc && sel == FBSM_SEL_NONE |=> O_PSLVERR && O_PRDATA == 32'h00000000)
    else $error("unmapped access not flagged");
  a_boot_mode: assert property (s_boot |=> O_IS_MASTER == $past(I_SEL_CLOSED | ~I_NV_VALID))
    else $error("boot mode selection wrong");
  a_mode_frozen: assert property (s_r.st != FBSM_BOOT |=> $stable(O_IS_MASTER) && $stable(O_IS_PASSIVE))
    else $error("mode changed without power cycle");
  a_cfg_write_gate: assert property (s_cfg_wr_bad |=> $stable(s_r.cfg) && !O_NV_WR)
    else $error("configuration written while not master");
  a_station_addr: assert property (s_r.st != FBSM_BOOT |-> O_IS_MASTER ? O_STATION_ADDR == MASTER_ADDR
                                            : O_STATION_ADDR >= ADDR_MIN)
    else $error("station address out of range");
  a_sync_hold: assert property (s_sync_end ##1 !I_XCHG_DONE [*2] |-> !O_PROG_EN)
    else $error("synchronous slave ran before transfer end");
  a_async_runs: assert property (s_async_idle |=> O_PROG_EN)
    else $error("asynchronous slave stalled without request");
  a_halt_on_fail: assert property (halt_cond && s_r.st != FBSM_BOOT |=> s_r.st == FBSM_HALT && !O_PROG_EN)
    else $error("active slave did not halt on failure");
  a_run_on_fail: assert property (active && s_r.cfg[CFG_HALT_BIT] && s_r.st != FBSM_BOOT
                                  |-> s_r.st != FBSM_HALT)
    else $error("slave halted although run was selected");
  a_fail_timeout: assert property (s_r.st != FBSM_BOOT && !O_IS_MASTER && s_r.tmr >= FAIL_LIM && !I_XCHG_DONE
                                   |=> O_BUS_FAIL)
    else $error("bus failure not flagged on timeout");
  a_fail_clear: assert property (s_r.st != FBSM_BOOT && !O_IS_MASTER && I_XCHG_DONE |=> !O_BUS_FAIL)
    else $error("bus failure not cleared by exchange");

endmodule

// *** include/fbsm_pkg.sv ***
// Purpose: constants and types of the fieldbus slave mode configuration block
// Assumes: 25 MHz clock, APB with 32-bit data, one word per register
// Notes:   the configuration byte is retained outside, in nonvolatile storage
package fbsm_pkg;
  localparam int CLK_FREQ_MHZ    = 25;
  localparam int FAIL_TIMEOUT_US = 10000;
  localparam int FAIL_CYC        = FAIL_TIMEOUT_US * CLK_FREQ_MHZ;
  localparam int TMR_W           = 24;

  localparam logic [7:0] OFS_CFG   = 8'h00;
  localparam logic [7:0] OFS_STS   = 8'h04;
  localparam logic [7:0] OFS_MASK  = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;

  // configuration byte layout
  localparam int CFG_ADDR_W   = 5;
  localparam int CFG_HALT_BIT = 5;
  localparam int CFG_KIND_BIT = 6;
  localparam int CFG_RATE_BIT = 7;
  localparam logic [7:0] CFG_RST = 8'h02;

  localparam logic [4:0] MASTER_ADDR = 5'h01;
  localparam logic [4:0] ADDR_MIN    = 5'h02;
  localparam logic [4:0] ADDR_MAX    = 5'h1F;

  // sticky event bits, same layout in the mask
  localparam int STS_W       = 3;
  localparam int STS_FAIL    = 0;
  localparam int STS_OK      = 1;
  localparam int STS_REFUSED = 2;
  localparam logic [STS_W-1:0] MASK_RST = 3'h0;

  // read-only state word layout
  localparam int SW_MASTER  = 0;
  localparam int SW_PASSIVE = 1;
  localparam int SW_FAIL    = 2;
  localparam int SW_ST_LSB  = 3;
  localparam int SW_PROG    = 5;
  localparam int SW_ADR_LSB = 8;

  typedef enum logic [1:0] {
    FBSM_BOOT  = 2'h0,
    FBSM_RUN   = 2'h1,
    FBSM_XWAIT = 2'h3,
    FBSM_HALT  = 2'h2
  } fbsm_st_t;

  typedef enum logic [2:0] {
    FBSM_SEL_CFG   = 3'h0,
    FBSM_SEL_STS   = 3'h1,
    FBSM_SEL_MASK  = 3'h2,
    FBSM_SEL_STATE = 3'h3,
    FBSM_SEL_NONE  = 3'h4
  } fbsm_sel_t;

  typedef struct packed {
    fbsm_st_t          st;
    logic              master;
    logic              passive;
    logic [7:0]        cfg;
    logic [4:0]        addr;
    logic              fail;
    logic [TMR_W-1:0]  tmr;
    logic [STS_W-1:0]  sts;
    logic [STS_W-1:0]  mask;
    logic              irq;
    logic              prog_en;
    logic              nv_wr;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } fbsm_state_t;

  localparam fbsm_state_t STATE_RST = '{
    st: FBSM_BOOT, master: 1'b1, passive: 1'b0, cfg: CFG_RST,
    addr: MASTER_ADDR, fail: 1'b0, tmr: 24'h000000, sts: 3'h0,
    mask: MASK_RST, irq: 1'b0, prog_en: 1'b0, nv_wr: 1'b0,
    pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000
  };
endpackage

// *** sim/fbsm_fbm.sv ***
// Purpose: fieldbus master model that polls one slave station
// Assumes: drives just after the rising edge of the station clock
// Notes:   request is held until the done pulse has been sent
module fbsm_fbm (
  input  wire logic i_clk,
  output logic      o_req,
  output logic      o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // this master owns station 1; it is attached in every run but only driven in slave runs
  localparam logic [4:0] OWN_ADDR = 5'h01;
  initial begin
    o_req  = 1'b0;
    o_done = 1'b0;
  end
  // n sets how slow the master answers
  task automatic xfer(input int n);
    @(posedge i_clk);
    o_req <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_done <= 1'b1;
    @(posedge i_clk);
    o_done <= 1'b0;
    o_req  <= 1'b0;
  endtask
endmodule

// *** sim/fieldbus_slave_mode_config_tb.sv ***
// Purpose: register and mode checks of the slave mode configuration block
// Assumes: short failure timeout set by parameter
// Notes:   every boot stands for a power cycle
module fieldbus_slave_mode_config_tb;
  import fbsm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FCYC = 40;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        sel = 1'b1, nvv = 1'b0, cyc_end = 1'b0, xreq, xdone;
  logic [7:0]  paddr = 8'h00, nvcfg = 8'h00, nvd;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, is_m, is_p, fail, prog, nvw, err, nvw_seen;
  logic [4:0]  sta;
  logic [7:0]  wv [5] = '{8'h01, 8'h02, 8'h20, 8'h1F, 8'h84};
  logic        wok [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  int          miscompares = 0, samples_checked = 0;

  always #20 clk = ~clk;

  fbsm_top #(.P_FAIL_CYC(FCYC)) fbsm_top_i (
    .I_MCLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_SEL_CLOSED(sel), .I_NV_VALID(nvv),
    .I_NV_CFG(nvcfg), .I_CYCLE_END(cyc_end), .I_XCHG_REQ(xreq), .I_XCHG_DONE(xdone),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_IRQ(irq),
    .O_IS_MASTER(is_m), .O_IS_PASSIVE(is_p), .O_STATION_ADDR(sta), .O_BUS_FAIL(fail),
    .O_PROG_EN(prog), .O_NV_WR(nvw), .O_NV_DATA(nvd)
  );
  fbsm_fbm fbsm_fbm_i (.i_clk(clk), .o_req(xreq), .o_done(xdone));

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // read data, error and store strobe are all taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      miscompares++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    nvw_seen = nvw;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic boot(input logic s, input logic v, input logic [7:0] c);
    @(posedge clk);
    rst_n <= 1'b0;
    sel <= s;
    nvv <= v;
    nvcfg <= c;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
  endtask

  task automatic cend();
    @(posedge clk);
    cyc_end <= 1'b1;
    @(posedge clk);
    cyc_end <= 1'b0;
    #1;
  endtask

  task automatic wfail();
    int n;
    for (n = 0; n < 200 && fail !== 1'b1; n++) @(posedge clk);
    if (n == 200) begin
      miscompares++;
      conclude();
    end
    tick(2);
  endtask

  initial begin
    boot(1'b1, 1'b0, 8'h00);
    chk({is_m, sta}, {1'b1, 5'h01});
    apb(1'b0, OFS_STATE, 32'h0);
    chk(rd & 32'h00001F27, 32'h00000121);
    apb(1'b1, OFS_MASK, 32'h4);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFS_CFG, {24'h0, wv[i]});
      chk(nvw_seen, wok[i]);
    end
    chk({is_m, nvd, irq}, {1'b1, 8'h84, 1'b1});
    apb(1'b0, OFS_STS, 32'h0);
    chk(rd, 32'h4);
    apb(1'b0, OFS_STS, 32'h0);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, 8'h10, 32'h55);
    chk(err, 1'b1);
    apb(1'b0, OFS_CFG, 32'h0);
    chk(rd, 32'h84);
    tend("master");
    boot(1'b0, 1'b1, 8'h84);
    chk({is_m, is_p, sta, prog}, {1'b0, 1'b0, 5'h04, 1'b1});
    cend();
    chk(prog, 1'b1);
    fork
      fbsm_fbm_i.xfer(6);
      begin
        cend();
        chk(prog, 1'b0);
      end
    join
    #1;
    chk(prog, 1'b1);
    apb(1'b1, OFS_MASK, 32'h1);
    wfail();
    chk({fail, prog, is_p, irq}, 4'b1001);
    apb(1'b0, OFS_STS, 32'h0);
    chk(rd, 32'h1);
    fbsm_fbm_i.xfer(1);
    tick(2);
    chk({fail, prog, irq}, 3'b010);
    tend("async halt");
    boot(1'b0, 1'b1, 8'h23);
    chk(sta, 5'h03);
    cend();
    chk(prog, 1'b0);
    fbsm_fbm_i.xfer(2);
    #1;
    chk(prog, 1'b1);
    apb(1'b1, OFS_CFG, 32'h85);
    chk(nvw_seen, 1'b0);
    wfail();
    chk({fail, prog}, 2'b11);
    tend("sync run");
    boot(1'b0, 1'b1, 8'h41);
    chk({is_p, prog, sta}, {1'b1, 1'b0, 5'h02});
    tend("passive");
    boot(1'b1, 1'b1, 8'h84);
    chk({is_m, sta, nvd}, {1'b1, 5'h01, 8'h84});
    tend("strap");
    conclude();
  end
endmodule
